// ---- design/gpib_status_pkg.sv ----
// Shared constants for the bus status byte and talk/listen mode block.
// Assumes a 100 MHz instrument clock; all counts derive from it.
`default_nettype none
package gpib_status_pkg;

  // Status byte layout
  localparam int STATUS_BITS = 6;
  localparam int RQS_POS = 6;
  localparam int UNUSED_POS = 7;
  localparam int DATA_READY_POS = 0;
  localparam int CODE_ERR_POS = 1;
  localparam int ADDR_BITS = 5;

  // Mask reset value and the bit that can never be cleared
  localparam logic [5:0] MASK_RESET = 6'h02;
  localparam logic [5:0] MASK_FIXED = 6'h02;
  localparam logic [5:0] STATUS_RESET = 6'h00;

  // All-ones address selects talk-status-only together with talk-only
  localparam logic [4:0] ADDR_ALL_ONES = 5'h1f;

  // Data settle time before data-valid is asserted
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS = 500;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = 6;

  typedef enum logic [1:0] {
    MODE_ADDRESSED,
    MODE_TALK_ONLY,
    MODE_TALK_STATUS,
    MODE_LISTEN_ONLY
  } bus_mode_t;

  typedef enum logic [2:0] {
    SH_IDLE,
    SH_SETTLE,
    SH_VALID,
    SH_RELEASE
  } src_state_t;

endpackage
`default_nettype wire

// ---- design/pin_sync.sv ----
// Two-stage synchroniser for a group of pin levels.
// Assumes the pins are quasi-static relative to the clock.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk, // Instrument clock
  input wire logic i_rst, // Synchronous reset
  input wire logic [WIDTH-1:0] i_async, // Pin levels
  output logic [WIDTH-1:0] o_sync // Synchronised levels
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule
`default_nettype wire

// ---- design/gpib_status_and_talk_modes.sv ----
// Status byte, service request and switch-selected talk/listen modes.
// Assumes bus message decode arrives as same-clock pulses; pins are raw.
//
// Functional notes
// - Status bits 0-5 report only conditions enabled by their mask bit.
// - After reset or preset only the code error bit is unmasked.
// - Any set status bit sets request-service bit and drives service request.
// - Panel request lamp follows request only at a display refresh.
// - Set status bits stay latched until the byte is read.
// - Masked conditions set no status bit, no request-service, no request.
// - Masked bits read zero; enabled bits need a condition after enabling.
// - Status byte is frozen while serial poll mode is active.
// - Controller polls after a request; device answers with status byte.
// - Poll read clears ended conditions; persisting ones set again at once.
// - Device clear, preset and power-up clear the status byte.
// - Serial poll disable or abort clears the status byte.
// - Going from remote to local leaves the status byte alone.
// - Abort stops talker and listener activity at once.
// - Control passing is ignored; no parallel poll bit is ever sent.
// - Lamps show remote, listen and talk; remote lamp off in local.
// - Readout shows five address bits, talk-only, listen-only, live request.
// - Talk-only beats listen-only; all-ones address plus talk-only is status-only.
// - Talk-only sends after each measurement; free-run restarts if unready.
// - Status-only mode sends status copy in data mode, clears after send.
// - Each status-only byte is one data-valid pulse.
// - Listen-only with remote enable ignores local, abort and serial poll.
// - Code error mask bit is fixed at one.
// - Status bit zero means measurement data ready when unmasked.
`timescale 1ns/1ps
`default_nettype none
module gpib_status_and_talk_modes #(
  parameter int SETTLE_CYCLES = gpib_status_pkg::SETTLE_CYC
) (
  input wire logic i_clk, // Instrument clock
  input wire logic i_rst, // Power-up reset, active high
  input wire logic i_preset, // Instrument preset pulse
  input wire logic [5:0] i_cond, // Instrument condition levels
  input wire logic i_mask_wr, // Mask write strobe
  input wire logic [5:0] i_mask_data, // New mask value
  input wire logic i_dcl, // Device clear message pulse
  input wire logic i_spd, // Serial poll disable pulse
  input wire logic i_abort, // Abort message pulse
  input wire logic i_spoll_mode, // Serial poll mode level
  input wire logic i_spoll_read, // Status byte taken by poll
  input wire logic i_my_talk, // Addressed to talk pulse
  input wire logic i_my_listen, // Addressed to listen pulse
  input wire logic i_untalk, // Untalk pulse
  input wire logic i_unlisten, // Unlisten pulse
  input wire logic i_go_remote, // Remote entered pulse
  input wire logic i_go_local, // Local message pulse
  input wire logic i_disp_refresh, // Front panel refresh pulse
  input wire logic i_meas_done, // Measurement complete pulse
  input wire logic [7:0] i_meas_byte, // Measurement output byte
  input wire logic i_free_run_trigger_mode, // Free-run trigger selected
  input wire logic [4:0] i_addr_sw, // Address switch pins
  input wire logic i_talk_only_switch, // Talk-only switch pin
  input wire logic i_listen_only_switch, // Listen-only switch pin
  input wire logic i_ren, // Remote enable line true
  input wire logic i_atn, // Attention line true
  input wire logic i_nrfd, // Not ready for data true
  input wire logic i_ndac, // Not data accepted true
  output logic o_srq, // Service request line true
  output logic [7:0] o_service_status_byte, // Status byte value
  output logic o_spoll_respond, // Answer serial polls
  output logic [7:0] o_dio, // Data lines value
  output logic o_dio_oe, // Data lines driven
  output logic o_dav, // Data valid true
  output logic o_dav_oe, // Data valid driven
  output logic o_ppoll_oe, // Parallel poll drive
  output logic o_meas_restart, // Start new measurement pulse
  output logic o_listen_active, // Listener active level
  output logic o_remote_lamp, // Remote annunciator
  output logic o_listen_lamp, // Listen annunciator
  output logic o_talk_lamp, // Talk annunciator
  output logic o_srq_lamp, // Request annunciator
  output logic [4:0] o_readout_addr, // Readout address bits
  output logic [2:0] o_mode_and_request_digits // Readout T, L, S
);

  logic [7:0] pins_sync;
  logic [4:0] addr_s;
  logic ton_s;
  logic lon_s;
  logic ren_s;
  logic atn_s;
  logic nrfd_s;
  logic ndac_s;
  logic [5:0] mask_ff;
  logic [5:0] status_ff;
  logic [5:0] nxt_status;
  logic rqs;
  logic status_clr;
  logic tso_sent;
  logic abort_ok;
  logic talk_addr_ff;
  logic listen_addr_ff;
  logic remote_ff;
  logic meas_pend_ff;
  logic [7:0] meas_hold_ff;
  logic [7:0] dio_ff;
  logic dav_ff;
  logic drive_ff;
  logic tso_src_ff;
  logic restart_ff;
  logic [gpib_status_pkg::SETTLE_W-1:0] settle_ff;
  logic remote_lamp_ff;
  logic listen_lamp_ff;
  logic talk_lamp_ff;
  logic srq_lamp_ff;
  logic [4:0] ro_addr_ff;
  logic [2:0] ro_digits_ff;
  gpib_status_pkg::bus_mode_t mode;
  gpib_status_pkg::src_state_t sh_ff;

  // Mode from the switch settings
  function automatic gpib_status_pkg::bus_mode_t decode_mode(
    input logic [4:0] addr,
    input logic talk_only_switch,
    input logic listen_only_switch
  );
    gpib_status_pkg::bus_mode_t m;
    m = gpib_status_pkg::MODE_ADDRESSED;
    if (talk_only_switch && addr == gpib_status_pkg::ADDR_ALL_ONES) begin
      m = gpib_status_pkg::MODE_TALK_STATUS;
    end else if (talk_only_switch) begin
      m = gpib_status_pkg::MODE_TALK_ONLY;
    end else if (listen_only_switch) begin
      m = gpib_status_pkg::MODE_LISTEN_ONLY;
    end
    return m;
  endfunction

  // Switches and bus lines all come from pins
  pin_sync #(
    .WIDTH(8)
  ) u_sw_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_addr_sw, i_talk_only_switch, i_listen_only_switch, i_ren}),
    .o_sync(pins_sync)
  );

  pin_sync #(
    .WIDTH(3)
  ) u_bus_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_atn, i_nrfd, i_ndac}),
    .o_sync({atn_s, nrfd_s, ndac_s})
  );

  assign addr_s = pins_sync[7:3];
  assign ton_s = pins_sync[2];
  assign lon_s = pins_sync[1];
  assign ren_s = pins_sync[0];
  assign mode = decode_mode(addr_s, ton_s, lon_s);

  // Listen-only with remote enable ignores abort
  assign abort_ok = i_abort && !(mode == gpib_status_pkg::MODE_LISTEN_ONLY && ren_s);

  // Mask: code error bit can never be cleared
  always_ff @(posedge i_clk) begin
    if (i_rst || i_preset || i_dcl) begin
      mask_ff <= gpib_status_pkg::MASK_RESET;
    end else if (i_mask_wr) begin
      mask_ff <= i_mask_data | gpib_status_pkg::MASK_FIXED;
    end
  end

  // Any of these drops ended conditions from the byte; local transitions are absent on purpose
  assign status_clr = i_spoll_read || i_spd || abort_ok || tso_sent;

  // Next status: masked conditions only; frozen during a poll
  always_comb begin
    nxt_status = status_ff;
    if (status_clr) begin
      nxt_status = i_cond & mask_ff;
    end else if (!i_spoll_mode) begin
      nxt_status = (status_ff | i_cond) & mask_ff;
    end else begin
      nxt_status = status_ff;
    end
    if (i_mask_wr) begin
      // A bit masked now must read zero; a newly unmasked one waits
      nxt_status = nxt_status & (i_mask_data | gpib_status_pkg::MASK_FIXED) & mask_ff;
    end
  end

  // Status register
  always_ff @(posedge i_clk) begin
    if (i_rst || i_preset || i_dcl) begin
      status_ff <= gpib_status_pkg::STATUS_RESET;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // Request bit from any set status bit
  assign rqs = |status_ff;
  assign o_srq = rqs;
  assign o_service_status_byte = {1'b0, rqs, status_ff};
  // Poll answer except in listen-only operation with remote enable
  assign o_spoll_respond = !(mode == gpib_status_pkg::MODE_LISTEN_ONLY && ren_s);
  // No controller or parallel poll logic is built
  assign o_ppoll_oe = 1'b0;

  // Addressed state; abort drops both roles at once
  always_ff @(posedge i_clk) begin
    if (i_rst || abort_ok) begin
      talk_addr_ff <= 1'b0;
      listen_addr_ff <= 1'b0;
    end else begin
      if (i_my_talk) begin
        talk_addr_ff <= 1'b1;
      end else if (i_untalk || i_my_listen) begin
        talk_addr_ff <= 1'b0;
      end
      if (i_my_listen) begin
        listen_addr_ff <= 1'b1;
      end else if (i_unlisten || i_my_talk) begin
        listen_addr_ff <= 1'b0;
      end
    end
  end

  // Remote state; listen-only ignores the local message
  always_ff @(posedge i_clk) begin
    if (i_rst || !ren_s) begin
      remote_ff <= 1'b0;
    end else if (mode == gpib_status_pkg::MODE_LISTEN_ONLY) begin
      remote_ff <= 1'b1;
    end else if (i_go_local) begin
      remote_ff <= 1'b0;
    end else if (i_go_remote) begin
      remote_ff <= 1'b1;
    end
  end

  assign o_listen_active = (mode == gpib_status_pkg::MODE_LISTEN_ONLY && ren_s) ||
                           (mode == gpib_status_pkg::MODE_ADDRESSED && listen_addr_ff);

  // Pending measurement for talk-only output
  always_ff @(posedge i_clk) begin
    if (i_rst || abort_ok || mode != gpib_status_pkg::MODE_TALK_ONLY) begin
      meas_pend_ff <= 1'b0;
      meas_hold_ff <= 8'h00;
    end else if (i_meas_done) begin
      meas_pend_ff <= 1'b1;
      meas_hold_ff <= i_meas_byte;
    end else if (sh_ff == gpib_status_pkg::SH_IDLE && meas_pend_ff) begin
      // Unready listener: free-run drops the byte, else keeps waiting
      if (!nrfd_s || i_free_run_trigger_mode) begin
        meas_pend_ff <= 1'b0;
      end
    end
  end

  // Restart pulse when free-run finds the listener unready
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= sh_ff == gpib_status_pkg::SH_IDLE && meas_pend_ff && nrfd_s &&
                    i_free_run_trigger_mode && !abort_ok && !i_meas_done &&
                    mode == gpib_status_pkg::MODE_TALK_ONLY;
    end
  end

  assign o_meas_restart = restart_ff;

  // Source handshake; one data-valid pulse per byte
  always_ff @(posedge i_clk) begin
    if (i_rst || abort_ok) begin
      sh_ff <= gpib_status_pkg::SH_IDLE;
      dio_ff <= 8'h00;
      dav_ff <= 1'b0;
      drive_ff <= 1'b0;
      tso_src_ff <= 1'b0;
      settle_ff <= '0;
    end else begin
      case (sh_ff)
        gpib_status_pkg::SH_IDLE: begin
          dav_ff <= 1'b0;
          drive_ff <= 1'b0;
          if (mode == gpib_status_pkg::MODE_TALK_STATUS && !atn_s && !nrfd_s) begin
            dio_ff <= o_service_status_byte;
            tso_src_ff <= 1'b1;
            drive_ff <= 1'b1;
            settle_ff <= '0;
            sh_ff <= gpib_status_pkg::SH_SETTLE;
          end else if (mode == gpib_status_pkg::MODE_TALK_ONLY && meas_pend_ff &&
                       !nrfd_s && !i_meas_done) begin
            dio_ff <= meas_hold_ff;
            tso_src_ff <= 1'b0;
            drive_ff <= 1'b1;
            settle_ff <= '0;
            sh_ff <= gpib_status_pkg::SH_SETTLE;
          end
        end
        gpib_status_pkg::SH_SETTLE: begin
          // Data must settle before it is declared valid
          if (settle_ff >= gpib_status_pkg::SETTLE_W'(SETTLE_CYCLES - 1)) begin
            dav_ff <= 1'b1;
            sh_ff <= gpib_status_pkg::SH_VALID;
          end else begin
            settle_ff <= settle_ff + 1'b1;
          end
        end
        gpib_status_pkg::SH_VALID: begin
          if (!ndac_s) begin
            dav_ff <= 1'b0;
            sh_ff <= gpib_status_pkg::SH_RELEASE;
          end
        end
        gpib_status_pkg::SH_RELEASE: begin
          // Wait for acceptors to rearm before the next byte
          drive_ff <= 1'b0;
          if (ndac_s) begin
            sh_ff <= gpib_status_pkg::SH_IDLE;
          end
        end
        default: begin
          sh_ff <= gpib_status_pkg::SH_IDLE;
        end
      endcase
    end
  end

  // Status clears once the copy is accepted
  assign tso_sent = sh_ff == gpib_status_pkg::SH_VALID && !ndac_s && tso_src_ff;

  assign o_dio = dio_ff;
  assign o_dio_oe = drive_ff;
  assign o_dav = dav_ff;
  assign o_dav_oe = drive_ff;

  // Lamps only change at a display refresh, never straight from the line
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      remote_lamp_ff <= 1'b0;
      listen_lamp_ff <= 1'b0;
      talk_lamp_ff <= 1'b0;
      srq_lamp_ff <= 1'b0;
    end else if (i_disp_refresh) begin
      remote_lamp_ff <= remote_ff;
      listen_lamp_ff <= o_listen_active;
      talk_lamp_ff <= talk_addr_ff || drive_ff;
      srq_lamp_ff <= rqs;
    end
  end

  assign o_remote_lamp = remote_lamp_ff;
  assign o_listen_lamp = listen_lamp_ff;
  assign o_talk_lamp = talk_lamp_ff;
  assign o_srq_lamp = srq_lamp_ff;

  // Address readout is live, updated every cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ro_addr_ff <= 5'h00;
      ro_digits_ff <= 3'h0;
    end else begin
      ro_addr_ff <= addr_s;
      ro_digits_ff <= {ton_s, lon_s, rqs};
    end
  end

  assign o_readout_addr = ro_addr_ff;
  assign o_mode_and_request_digits = ro_digits_ff;

endmodule
`default_nettype wire

// ---- sim/gpib_status_and_talk_modes_monitor.sv ----
// Checker for status byte, request line, request lamp and data handshake.
// Assumes it is bound to the block's top; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module gpib_status_and_talk_modes_monitor #(
  parameter int SETTLE_CYCLES = 2
) (
  input wire logic i_clk, i_rst, i_preset, i_mask_wr, i_dcl, i_spd, i_abort,
  input wire logic i_spoll_mode, i_spoll_read, i_disp_refresh,
  input wire logic [5:0] i_cond,
  input wire logic o_srq, o_dio_oe, o_dav, o_dav_oe, o_ppoll_oe, o_srq_lamp,
  input wire logic [7:0] o_service_status_byte,
  input wire logic [2:0] o_mode_and_request_digits
);
  // Slack beyond the settle count for the source state steps
  localparam int DAV_MAX = SETTLE_CYCLES + 3;
  logic [7:0] sb;
  logic clr;
  // Every event that may legally drop a latched bit
  assign sb = o_service_status_byte;
  assign clr = i_spoll_read | i_spd | i_abort | i_dcl | i_preset | i_mask_wr | o_dav | i_rst;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_settle;
    !o_dav ##[1:DAV_MAX] o_dav;
  endsequence
  sequence s_release;
    !o_dav ##[0:2] !o_dio_oe;
  endsequence
  a_no_ppoll: assert property (o_ppoll_oe == 1'b0)
    else $error("parallel poll driven");
  a_rqs_sum: assert property (o_srq == sb[6] && sb[6] == |sb[5:0] && !sb[7])
    else $error("request bit or line wrong");
  a_set_cause: assert property (!(|(sb[5:0] & ~$past(sb[5:0]) & ~$past(i_cond))))
    else $error("status bit set without condition");
  a_hold_latch: assert property (|($past(sb[5:0]) & ~sb[5:0]) |-> $past(clr))
    else $error("status bit dropped without clear");
  a_poll_freeze: assert property (i_spoll_mode && !clr |=> $stable(sb))
    else $error("status changed in serial poll");
  a_dcl_zero: assert property (i_dcl || i_preset |=> sb == 8'h00)
    else $error("device clear left status");
  a_spd_clear: assert property (i_spd && i_cond == 6'h00 |=> sb == 8'h00)
    else $error("poll disable left status");
  a_lamp_sample: assert property (i_disp_refresh |=> o_srq_lamp == $past(sb[6]))
    else $error("request lamp not sampled");
  a_dav_settle: assert property ($rose(o_dio_oe) |-> s_settle)
    else $error("data valid late");
  a_dav_drop: assert property ($fell(o_dav) |-> s_release)
    else $error("data lines held after valid");
  a_dav_driven: assert property (o_dav |-> o_dav_oe)
    else $error("data valid not driven");
  a_abort_stop: assert property (i_abort && o_mode_and_request_digits[2] |=> !o_dav && !o_dio_oe)
    else $error("talker kept going after abort");
endmodule
bind gpib_status_and_talk_modes gpib_status_and_talk_modes_monitor #(
  .SETTLE_CYCLES(SETTLE_CYCLES)
) mon_inst (
  .i_clk, .i_rst, .i_preset, .i_mask_wr, .i_dcl, .i_spd, .i_abort, .i_spoll_mode,
  .i_spoll_read, .i_disp_refresh, .i_cond, .o_srq, .o_dio_oe, .o_dav, .o_dav_oe,
  .o_ppoll_oe, .o_srq_lamp, .o_service_status_byte, .o_mode_and_request_digits
);
`default_nettype wire

// ---- sim/bus_listener_model.sv ----
// Listener model on the far side of the data handshake.
// Assumes true-high lines; a released data-valid line reads false.
`timescale 1ns/1ps
`default_nettype none
module bus_listener_model (
  input wire logic i_clk, // Clock
  input wire logic i_dav, // Data valid
  input wire logic i_dav_oe, // Valid driven
  input wire logic [7:0] i_dio, // Data lines
  input wire logic i_busy, // Stay not ready
  input wire logic i_hold, // Withhold accept
  output logic o_nrfd, // Not ready
  output logic o_ndac, // Not accepted
  output var int o_count, // Bytes taken
  output logic [7:0] o_last // Last byte
);
  logic got = 1'b0;
  initial begin
    o_nrfd = 1'b0;
    o_ndac = 1'b1;
    o_count = 0;
    o_last = 8'h00;
  end
  // Acts 2 ns after each edge, so bench inputs set at 1 ns are seen
  always @(posedge i_clk) begin
    #2;
    if (!got && i_dav && i_dav_oe) begin
      got = 1'b1;
      o_last = i_dio;
      o_count = o_count + 1;
      o_nrfd = 1'b1;
    end else if (got && !(i_dav && i_dav_oe)) begin
      got = 1'b0;
      o_ndac = 1'b1;
      o_nrfd = i_busy;
    end else begin
      o_ndac = !got || i_hold;
      o_nrfd = got ? o_nrfd : i_busy;
    end
  end
endmodule
`default_nettype wire

// ---- sim/gpib_status_and_talk_modes_tb.sv ----
// Bench: status byte model, lamps, readout and talk modes against the block.
// Assumes the listener model on the handshake; pins settle within 5 cycles.
`timescale 1ns/1ps
`default_nettype none
module gpib_status_and_talk_modes_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [13:0] pul = '0;
  logic [5:0] cond = '0, mdat = '0, st = '0, msk = 6'h02;
  logic smode = 0, frun = 0, talk_only_switch = 0, listen_only_switch = 0, ren = 0, atn = 1, busy = 0, hold = 0;
  logic [4:0] addr = '0, raddr;
  logic [7:0] mbyte = '0, sb, dio, rx_b;
  logic srq, resp, dio_oe, dav, dav_oe, ppoll, restart, nrfd, ndac, lact;
  logic [3:0] lamp;
  logic [2:0] dig;
  int fails = 0, comparisons = 0, rx_n, rs_n = 0, k, n0;
  initial forever #5 i_clk = ~i_clk;
  gpib_status_and_talk_modes #(.SETTLE_CYCLES(2)) gpib_status_and_talk_modes_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_preset(pul[0]), .i_cond(cond), .i_mask_wr(pul[1]),
    .i_mask_data(mdat), .i_dcl(pul[2]), .i_spd(pul[3]), .i_abort(pul[4]),
    .i_spoll_mode(smode), .i_spoll_read(pul[5]), .i_my_talk(pul[6]), .i_my_listen(pul[7]),
    .i_untalk(pul[8]), .i_unlisten(pul[9]), .i_go_remote(pul[10]), .i_go_local(pul[11]),
    .i_disp_refresh(pul[12]), .i_meas_done(pul[13]), .i_meas_byte(mbyte),
    .i_free_run_trigger_mode(frun), .i_addr_sw(addr), .i_talk_only_switch(talk_only_switch),
    .i_listen_only_switch(listen_only_switch), .i_ren(ren), .i_atn(atn), .i_nrfd(nrfd), .i_ndac(ndac),
    .o_srq(srq), .o_service_status_byte(sb), .o_spoll_respond(resp), .o_dio(dio),
    .o_dio_oe(dio_oe), .o_dav(dav), .o_dav_oe(dav_oe), .o_ppoll_oe(ppoll),
    .o_meas_restart(restart), .o_listen_active(lact), .o_remote_lamp(lamp[3]),
    .o_listen_lamp(lamp[2]), .o_talk_lamp(lamp[1]), .o_srq_lamp(lamp[0]),
    .o_readout_addr(raddr), .o_mode_and_request_digits(dig)
  );
  bus_listener_model bus_listener_model_inst (
    .i_clk(i_clk), .i_dav(dav), .i_dav_oe(dav_oe), .i_dio(dio), .i_busy(busy),
    .i_hold(hold), .o_nrfd(nrfd), .o_ndac(ndac), .o_count(rx_n), .o_last(rx_b)
  );
  // Restart pulses stand one cycle, so count them at every edge
  always @(posedge i_clk) if (restart === 1'b1) rs_n <= rs_n + 1;
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Extra edge after each pulse so no signal is set twice in one step
  task automatic pulse(input int i);
    pul = 14'h0001 << i;
    tick(1);
    pul = '0;
    tick(1);
  endtask
  task automatic setc(input logic [5:0] c);
    cond = c;
    tick(1);
    cond = '0;
    tick(1);
    if (!smode) st = st | (c & msk);
  endtask
  task automatic wmask(input logic [5:0] m);
    mdat = m;
    pulse(1);
    msk = m | 6'h02;
    st = st & msk;
  endtask
  task automatic chk(input string n, input logic [7:0] s, e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cst();
    chk("status", sb, {1'b0, |st, st});
    chk("srq", {7'h00, srq}, {7'h00, |st});
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Bounded wait on the restart or the received-byte count
  task automatic waitn(input bit sel, input int n);
    for (k = 0; k < 400 && (sel ? rs_n : rx_n) < n; k++) tick(1);
    if (k >= 400) begin
      fails++;
      report_and_stop();
    end
  endtask
  initial begin
    void'($urandom(32'h8730));
    tick(5);
    i_rst = 1'b0;
    tick(1);
    cst();
    chk("ppoll", {7'h00, ppoll}, 8'h00);
    setc(6'h3f);
    cst();
    chk("lamp", {7'h00, lamp[0]}, 8'h00);
    pulse(12);
    chk("lamp", {7'h00, lamp[0]}, 8'h01);
    pulse(5);
    st = '0;
    cst();
    cond = 6'h02;
    tick(2);
    pulse(5);
    st = 6'h02;
    cst();
    cond = '0;
    $display("reset, mask and poll done");
    // Random masks; local every pass, then poll disable and abort in turn
    for (int i = 0; i < 6; i++) begin
      wmask(6'($urandom));
      setc(6'($urandom));
      cst();
      pulse(11);
      cst();
      pulse(i[0] ? 4 : 3);
      st = '0;
      cst();
    end
    wmask(6'h3f);
    smode = 1'b1;
    setc(6'h01);
    cst();
    smode = 1'b0;
    setc(6'h01);
    cst();
    pulse(2);
    st = '0;
    cst();
    pulse(0);
    msk = 6'h02;
    setc(6'h3f);
    cst();
    pulse(2);
    st = '0;
    $display("mask, freeze and clear done");
    ren = 1'b1;
    tick(5);
    pulse(10);
    pulse(7);
    pulse(12);
    chk("lamps", {4'h0, lamp}, 8'h0c);
    pulse(6);
    pulse(12);
    chk("lamps", {4'h0, lamp}, 8'h0a);
    pulse(11);
    pulse(8);
    pulse(12);
    chk("lamps", {4'h0, lamp}, 8'h00);
    addr = 5'($urandom_range(30));
    tick(5);
    chk("readout", {3'h0, raddr}, {3'h0, addr});
    chk("digits", {5'h00, dig}, 8'h00);
    listen_only_switch = 1'b1;
    tick(5);
    chk("respond", {7'h00, resp}, 8'h00);
    chk("listen", {7'h00, lact}, 8'h01);
    chk("digits", {5'h00, dig}, 8'h02);
    talk_only_switch = 1'b1;
    tick(5);
    chk("respond", {7'h00, resp}, 8'h01);
    chk("digits", {5'h00, dig}, 8'h06);
    $display("lamps and readout done");
    frun = 1'b1;
    busy = 1'b1;
    tick(5);
    pulse(13);
    waitn(1'b1, 1);
    chk("restarts", 8'(rs_n), 8'h01);
    frun = 1'b0;
    busy = 1'b0;
    tick(5);
    n0 = rx_n;
    mbyte = 8'($urandom);
    pulse(13);
    waitn(1'b0, n0 + 1);
    chk("data", rx_b, mbyte);
    listen_only_switch = 1'b0;
    ren = 1'b0;
    addr = 5'h1f;
    tick(5);
    setc(6'h02);
    n0 = rx_n;
    atn = 1'b0;
    waitn(1'b0, n0 + 1);
    chk("copy", rx_b, 8'h42);
    tick(10);
    st = '0;
    cst();
    // Accept withheld: whichever byte is in flight parks with valid up
    hold = 1'b1;
    tick(15);
    chk("held", {7'h00, dav}, 8'h01);
    atn = 1'b1;
    tick(4);
    pulse(4);
    chk("stop", {6'h00, dav, dio_oe}, 8'h00);
    hold = 1'b0;
    $display("talk modes done");
    report_and_stop();
  end
endmodule
`default_nettype wire
